// File: core/dsd_map.vh
// Constants for the drive status display and node identity block
`ifndef DSD_MAP_VH
`define DSD_MAP_VH
// APB register offsets
`define DSD_REG_STATUS 12'h000
`define DSD_REG_CTRL 12'h004
`define DSD_REG_NODE 12'h008
`define DSD_REG_SERIAL 12'h00C
// Control register fields
`define DSD_CTRL_TEST_BIT 0
`define DSD_CTRL_BLANK_BIT 1
`define DSD_CTRL_RESET 32'h0000_0000
// Serial frame format: baud, data bits, stop bits, parity none
`define DSD_BAUD 9600
`define DSD_DATA_BITS 8
`define DSD_STOP_BITS 1
// Character interval in ms and its cycle count at 100 MHz
`define DSD_CLK_HZ 100000000
`define DSD_CHAR_MS 500
`define DSD_CHAR_CYCLES ((`DSD_CLK_HZ / 1000) * `DSD_CHAR_MS)
// Character codes: 0-F are hex digits, then letters
`define DSD_CH_U 5'h10
`define DSD_CH_P 5'h11
`define DSD_CH_BLANK 5'h1F
`endif

// File: core/dsd_status_display.v
// Drive status lamps, 7-segment sequencer and node address, APB slave
// Behaviour
// RQ1 - Node address is upper switch times sixteen plus lower switch.
// RQ2 - Address zero is broadcast; never flagged as a valid own address.
// RQ3 - Installer gives each drive a distinct address from one upward.
// RQ4 - Serial link is 9600 baud, 8 data, 1 stop, no parity, no flow.
// RQ5 - Host adaptor drives the line only while it sends.
// RQ6 - Code characters advance every half second.
// RQ7 - Faults beat warnings, warnings beat normal codes.
// RQ8 - Normal codes U1, P, 0 and E.
// RQ9 - Decimal point lit while current is thermally limited.
// RQ10 - Warning E2/U2 on motor over 130 C.
// RQ11 - Warning E3/U3 on bridge temperature warning.
// RQ12 - Warnings E4/U4 position and E5/U5 velocity following error.
// RQ13 - Warnings E6/U6 brake resistor, E7/U7 CAN, E8/U8 limits.
// RQ14 - Warnings U9 software, Ua quick-stop, Ub encoder lost.
// RQ15 - Faults F1 over-current and F2 bus over 400 V.
// RQ16 - Faults F3 brake fuse and F4 rectifier heat on supply variants.
// RQ17 - Faults F5 amplifier heat-sink and F6 motor over 155 C.
// RQ18 - Faults F7 fatal software, F8 resolver, F9 control supply loss.
// RQ19 - Green lamp lit while DC bus is high.
// RQ20 - Amber lamps for mains applied and braking energy active.
// RQ21 - Supply variants get three lamps, others only the bus lamp.
// RQ22 - Active codes of one class are cycled through in turn.
// RQ23 - Class is chosen afresh at each character boundary. Code takes a lower class only after the second character.
//
// Added by the designer: the address map and the APB slave port.
`timescale 1ns/1ps
`include "dsd_map.vh"
module dsd_status_display #(
	parameter HAS_SUPPLY = 1,
	parameter [31:0] CHAR_CYCLES = `DSD_CHAR_CYCLES
) (
	// Clock and reset
	input wire i_clk,
	input wire i_sys_rst,
	// APB slave
	input wire i_psel,
	input wire i_penable,
	input wire i_pwrite,
	input wire [11:0] i_paddr,
	input wire [31:0] i_pwdata,
	output reg [31:0] o_prdata,
	output reg o_pready,
	output reg o_pslverr,
	// Front panel switches
	input wire [3:0] i_node_sw_upper,
	input wire [3:0] i_node_sw_lower,
	// Power conditions
	input wire i_dc_bus_high,
	input wire i_mains_applied,
	input wire i_braking_active,
	input wire i_self_param,
	input wire i_power_enabled,
	input wire i_thermal_limit,
	// Warning conditions, bit n-2 is code n (2 to 11, a=10, b=11)
	input wire [9:0] i_warn,
	// Fault conditions, bit n-1 is fault n (1 to 9)
	input wire [8:0] i_fault,
	// Lamps
	output reg o_bus_lamp,
	output reg o_mains_lamp,
	output reg o_braking_energy_lamp,
	// Display: character code and decimal point
	output reg [4:0] o_disp_char,
	output reg o_disp_dp,
	// Node identity
	output reg [7:0] o_node_addr,
	output reg o_node_valid
);

	localparam ST_FIRST = 2'd0;
	localparam ST_SECOND = 2'd1;
	localparam CL_NORMAL = 2'd0;
	localparam CL_WARN = 2'd1;
	localparam CL_FAULT = 2'd2;

	// Three-stage sampling of pins; change accepted when stages 2 and 3 agree
	reg [32:0] s1, s2, s3, clean;
	wire [32:0] raw = {i_node_sw_upper, i_node_sw_lower, i_dc_bus_high,
		i_mains_applied, i_braking_active, i_self_param, i_power_enabled,
		i_thermal_limit, i_warn, i_fault};
	genvar g;
	generate
		for (g = 0; g < 33; g = g + 1) begin : gsync
			always @(posedge i_clk) begin
				if (i_sys_rst) begin
					s1[g] <= 1'b0;
					s2[g] <= 1'b0;
					s3[g] <= 1'b0;
					clean[g] <= 1'b0;
				end else begin
					s1[g] <= raw[g];
					s2[g] <= s1[g];
					s3[g] <= s2[g];
					if (s2[g] == s3[g])
						clean[g] <= s3[g];
				end
			end
		end
	endgenerate

	wire [3:0] sw_up = clean[32:29];
	wire [3:0] sw_lo = clean[28:25];
	wire bus_hi = clean[24];
	wire mains = clean[23];
	wire braking = clean[22];
	wire self_param = clean[21];
	wire pwr_en = clean[20];
	wire therm = clean[19];
	wire [9:0] warn = clean[18:9];
	// Fault vector rebuilt directly from sampled fault bits
	wire [8:0] fault_in = clean[8:0];
	// Supply-only faults masked on variants without a supply
	wire [8:0] fault = HAS_SUPPLY ? fault_in :
		(fault_in & 9'h1F3); // RQ16

	// Registers
	reg [31:0] ctrl;
	wire test_mode = ctrl[`DSD_CTRL_TEST_BIT];
	wire blank = ctrl[`DSD_CTRL_BLANK_BIT];

	// Warnings with both E and U forms: E shown while enabled
	function [4:0] warn_letter;
		input [3:0] code;
		input en;
		begin
			if (code >= 4'd9 || !en)
				warn_letter = `DSD_CH_U;
			else
				warn_letter = 5'h0E;
		end
	endfunction

	// Next active index at or after start, wraps; returns start if none
	function [3:0] next_active;
		input [9:0] vec;
		input [3:0] start;
		input [3:0] len;
		integer k;
		reg found;
		reg [3:0] idx;
		reg [4:0] sum;
		begin
			found = 1'b0;
			next_active = start;
			for (k = 0; k < 10; k = k + 1) begin
				// Five-bit sum so the wrap never overflows
				sum = {1'b0, start} + {1'b0, k[3:0]};
				if (sum >= {1'b0, len})
					sum = sum - {1'b0, len};
				idx = sum[3:0];
				if (!found && vec[idx]) begin
					found = 1'b1;
					next_active = idx;
				end
			end
		end
	endfunction

	// One character of a code: first letter or second digit
	function [4:0] code_char;
		input [1:0] c;
		input [3:0] i;
		input second;
		input mains_on;
		input param_on;
		input en;
		begin
			case (c)
			CL_FAULT: begin
				if (second)
					code_char = {1'b0, i + 4'd1}; // RQ15 RQ17 RQ18
				else
					code_char = 5'h0F;
			end
			CL_WARN: begin
				if (second)
					code_char = {1'b0, i + 4'd2}; // RQ11 RQ12 RQ13
				else
					code_char = warn_letter(i + 4'd2, en); // RQ10 RQ14
			end
			default: begin
				// Normal codes: single characters except U1
				if (!mains_on)
					code_char = second ? 5'h01 : `DSD_CH_U; // RQ8
				else if (param_on)
					code_char = `DSD_CH_P;
				else if (en)
					code_char = 5'h0E;
				else
					code_char = 5'h00;
			end
			endcase
		end
	endfunction

	// Character timer
	reg [31:0] tmr;
	wire tick = (tmr == CHAR_CYCLES - 32'd1);
	always @(posedge i_clk) begin
		if (i_sys_rst)
			tmr <= 32'h0000_0000;
		else if (tick)
			tmr <= 32'h0000_0000;
		else
			tmr <= tmr + 32'd1;
	end

	// Sequencer
	reg [1:0] st;
	reg [1:0] cls;
	reg [3:0] idx;
	reg [4:0] next_char;
	reg [1:0] next_st;
	reg [1:0] next_cls;
	reg [3:0] next_idx;
	reg [3:0] cand;
	reg [1:0] pick_cls;
	reg [3:0] pick_idx;
	reg [1:0] show_cls;
	reg [3:0] show_idx;
	reg show_second;

	// Highest active class and the next code to show in it
	always @* begin
		pick_cls = CL_NORMAL;
		pick_idx = 4'd0;
		cand = 4'd0;
		if (|fault) begin // RQ7
			cand = (cls == CL_FAULT) ? idx + 4'd1 : 4'd0;
			pick_cls = CL_FAULT;
			pick_idx = next_active({1'b0, fault}, cand % 4'd9,
				4'd9); // RQ22
		end else if (|warn) begin // RQ7
			cand = (cls == CL_WARN) ? idx + 4'd1 : 4'd0;
			pick_cls = CL_WARN;
			pick_idx = next_active(warn, cand % 4'd10, 4'd10); // RQ22
		end
	end

	// A higher class cuts in at any character boundary
	always @* begin
		next_st = st;
		next_cls = cls;
		next_idx = idx;
		show_cls = cls;
		show_idx = idx;
		show_second = 1'b0;
		if (pick_cls > cls) begin // RQ23
			next_st = ST_SECOND;
			next_cls = pick_cls;
			next_idx = pick_idx;
			show_cls = pick_cls;
			show_idx = pick_idx;
		end else begin
			case (st)
			ST_FIRST: begin
				next_st = ST_SECOND;
			end
			ST_SECOND: begin
				// Same or lower class picked after the second character
				next_st = ST_FIRST;
				show_second = 1'b1;
				next_cls = pick_cls; // RQ23
				next_idx = pick_idx;
			end
			default: next_st = ST_FIRST;
			endcase
		end
		next_char = code_char(show_cls, show_idx, show_second, mains,
			self_param, pwr_en);
		if (blank)
			next_char = `DSD_CH_BLANK;
		else if (test_mode)
			next_char = 5'h08;
	end

	always @(posedge i_clk) begin
		if (i_sys_rst) begin
			st <= ST_FIRST;
			cls <= CL_NORMAL;
			idx <= 4'd0;
			o_disp_char <= `DSD_CH_BLANK;
			o_disp_dp <= 1'b0;
		end else begin
			if (tick) begin // RQ6
				st <= next_st;
				cls <= next_cls;
				idx <= next_idx;
				o_disp_char <= next_char;
			end
			o_disp_dp <= (therm & ~blank) | test_mode; // RQ9
		end
	end

	// Lamps and node address
	always @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_bus_lamp <= 1'b0;
			o_mains_lamp <= 1'b0;
			o_braking_energy_lamp <= 1'b0;
			o_node_addr <= 8'h00;
			o_node_valid <= 1'b0;
		end else begin
			o_bus_lamp <= bus_hi; // RQ19
			o_mains_lamp <= (HAS_SUPPLY != 0) & mains; // RQ20 RQ21
			o_braking_energy_lamp <= (HAS_SUPPLY != 0) & braking; // RQ20
			o_node_addr <= {sw_up, sw_lo}; // RQ1
			o_node_valid <= |{sw_up, sw_lo}; // RQ2
		end
	end

	// APB slave, one wait state
	wire acc = i_psel & i_penable & ~o_pready;
	wire hit = (i_paddr == `DSD_REG_STATUS) || (i_paddr == `DSD_REG_CTRL) ||
		(i_paddr == `DSD_REG_NODE) || (i_paddr == `DSD_REG_SERIAL);
	always @(posedge i_clk) begin
		if (i_sys_rst) begin
			ctrl <= `DSD_CTRL_RESET;
			o_prdata <= 32'h0000_0000;
			o_pready <= 1'b0;
			o_pslverr <= 1'b0;
		end else begin
			o_pready <= acc;
			o_pslverr <= acc & ~hit;
			o_prdata <= 32'h0000_0000;
			// Write lands at the edge that completes the access
			if (i_psel && i_penable && o_pready && i_pwrite &&
				i_paddr == `DSD_REG_CTRL)
				ctrl <= {30'd0, i_pwdata[1:0]};
			if (acc && !i_pwrite) begin
				case (i_paddr)
				`DSD_REG_STATUS:
					o_prdata <= {2'd0, cls, o_disp_dp, o_disp_char,
						warn, fault, bus_hi, mains, braking};
				`DSD_REG_CTRL: o_prdata <= ctrl;
				`DSD_REG_NODE:
					o_prdata <= {23'd0, o_node_valid, o_node_addr};
				`DSD_REG_SERIAL: // RQ4
					o_prdata <= {16'd`DSD_BAUD, 4'd0, 4'd`DSD_STOP_BITS,
						4'd0, 4'd`DSD_DATA_BITS};
				default: o_prdata <= 32'h0000_0000;
				endcase
			end
		end
	end

endmodule

// File: dv/dsd_host_model.sv
// Host side: runs one register bus transfer per request
`timescale 1ns/1ps
module dsd_host_model (
	// Clock, reset and request
	input wire i_clk,
	input wire i_sys_rst,
	input wire i_req,
	input wire i_wr,
	input wire [11:0] i_addr,
	input wire [31:0] i_wdata,
	output reg [31:0] o_rdata,
	output reg o_err,
	output reg o_done,
	// Bus side
	output reg o_psel = 1'b0,
	output reg o_penable = 1'b0,
	output reg o_pwrite = 1'b0,
	output reg [11:0] o_paddr = 12'h000,
	output reg [31:0] o_pwdata = 32'h0000_0000,
	input wire [31:0] i_prdata,
	input wire i_pready,
	input wire i_pslverr
);
	always @(posedge i_clk) begin
		o_done <= 1'b0;
		if (i_sys_rst) begin
			o_psel <= 1'b0;
			o_penable <= 1'b0;
		end else if (o_psel && o_penable && i_pready) begin
			o_psel <= 1'b0;
			o_penable <= 1'b0;
			// Released address and write-data lines never keep a stale value
			o_paddr <= ~o_paddr;
			o_pwdata <= ~o_pwdata;
			o_rdata <= i_prdata;
			o_err <= i_pslverr;
			o_done <= 1'b1;
		end else if (o_psel) begin
			o_penable <= 1'b1;
		end else if (i_req) begin
			o_psel <= 1'b1;
			o_pwrite <= i_wr;
			o_paddr <= i_addr;
			o_pwdata <= i_wdata;
		end
	end
endmodule

// File: dv/dsd_status_display_bench.sv
// Self-checking bench for the status display block
`timescale 1ns/1ps
`include "dsd_map.vh"
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin error_cnt++; \
	$display("[ERR] %s exp %0h got %0h", n, e, s); end end
module dsd_status_display_bench;
	logic i_clk = 1'b0, i_sys_rst = 1'b1, req = 1'b0, wr = 1'b0;
	logic [11:0] ad = 12'h000, pa;
	logic [31:0] wd = 32'h0000_0000, pwd, prd, rdata, seed = 32'h0000_0051;
	logic psel, pen, pw, prdy, pse, done, err, l_bus, l_mn, l_brk, dp, nv;
	logic [3:0] sw_u = 4'h0, sw_l = 4'h0;
	logic bus = 1'b0, mains = 1'b0, brk = 1'b0, sp = 1'b0, pe = 1'b0;
	logic th = 1'b0;
	logic [9:0] warn = 10'h000;
	logic [8:0] fault = 9'h000;
	logic [4:0] ch;
	logic [7:0] node;
	int error_cnt = 0, checks = 0;
	always #5 i_clk = ~i_clk;
	dsd_status_display #(.CHAR_CYCLES(32'd20)) dut (.i_clk(i_clk),
		.i_sys_rst(i_sys_rst), .i_psel(psel), .i_penable(pen), .i_pwrite(pw),
		.i_paddr(pa), .i_pwdata(pwd), .o_prdata(prd), .o_pready(prdy),
		.o_pslverr(pse), .i_node_sw_upper(sw_u), .i_node_sw_lower(sw_l),
		.i_dc_bus_high(bus), .i_mains_applied(mains), .i_braking_active(brk),
		.i_self_param(sp), .i_power_enabled(pe), .i_thermal_limit(th),
		.i_warn(warn), .i_fault(fault), .o_bus_lamp(l_bus),
		.o_mains_lamp(l_mn), .o_braking_energy_lamp(l_brk),
		.o_disp_char(ch), .o_disp_dp(dp), .o_node_addr(node),
		.o_node_valid(nv));
	dsd_host_model host (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_req(req),
		.i_wr(wr), .i_addr(ad), .i_wdata(wd), .o_rdata(rdata), .o_err(err),
		.o_done(done), .o_psel(psel), .o_penable(pen), .o_pwrite(pw),
		.o_paddr(pa), .o_pwdata(pwd), .i_prdata(prd), .i_pready(prdy),
		.i_pslverr(pse));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [31:0] node_word(logic [7:0] a);
		return {23'h0, |a, a};
	endfunction
	task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
		int n = 0;
		wr <= w;
		ad <= a;
		wd <= d;
		req <= 1'b1;
		@(posedge i_clk);
		req <= 1'b0;
		while (done !== 1'b1 && n < 50) begin
			@(posedge i_clk);
			n++;
		end
		if (n == 50) error_cnt++;
	endtask
	// Condition bits are {enabled, mains, self-param}
	task automatic disp(logic [8:0] f, logic [9:0] w, logic [2:0] c,
		logic [4:0] a, logic [4:0] b);
		logic [4:0] s[4];
		logic [4:0] p;
		int n = 0;
		fault <= f;
		warn <= w;
		{pe, mains, sp} <= c;
		repeat (80) @(posedge i_clk);
		p = ch;
		while (ch === p && n < 25) begin
			@(posedge i_clk);
			n++;
		end
		for (int i = 0; i < 4; i++) begin
			repeat (10) @(posedge i_clk);
			s[i] = ch;
			repeat (10) @(posedge i_clk);
		end
		`CHK("disp", 1'b1, ((s[0] === a && s[1] === b) || (s[0] === b &&
			s[1] === a)) && s[2] === s[0] && s[3] === s[1])
	endtask
	task automatic tally_and_finish();
		$display("errors %0d checks %0d", error_cnt, checks);
		if (error_cnt == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		repeat (10000) @(posedge i_clk);
		error_cnt++;
		tally_and_finish();
	end
	initial begin
		logic [31:0] r;
		logic [31:0] m;
		int n;
		repeat (8) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		@(posedge i_clk);
		`CHK("char", 5'h1F, ch)
		apb(1'b0, `DSD_REG_SERIAL, 32'h0);
		`CHK("serial", 32'h2580_0108, rdata)
		apb(1'b0, 12'h010, 32'h0);
		`CHK("unmapped", 1'b1, err)
		apb(1'b1, `DSD_REG_CTRL, 32'h0000_0001);
		repeat (22) @(posedge i_clk);
		`CHK("test dp", 1'b1, dp)
		`CHK("test char", 5'h08, ch)
		apb(1'b1, `DSD_REG_CTRL, 32'h0000_0002);
		apb(1'b0, `DSD_REG_CTRL, 32'h0);
		`CHK("ctrl", 32'h0000_0002, rdata)
		repeat (22) @(posedge i_clk);
		`CHK("blank", `DSD_CH_BLANK, ch)
		apb(1'b1, `DSD_REG_CTRL, `DSD_CTRL_RESET);
		for (int i = 0; i < 12; i++) begin
			r = rnd();
			{bus, mains, brk, th} <= r[3:0];
			{sw_u, sw_l} <= i == 0 ? 8'h00 : i == 1 ? 8'h1D : r[11:4];
			repeat (8) @(posedge i_clk);
			`CHK("lamps", {bus, mains, brk}, {l_bus, l_mn, l_brk})
			`CHK("dp", th, dp)
			apb(1'b0, `DSD_REG_NODE, 32'h0);
			`CHK("node", node_word({sw_u, sw_l}), rdata)
		end
		th <= 1'b0;
		disp(9'h001, 10'h001, 3'b110, 5'h0F, 5'h01);
		disp(9'h100, 10'h000, 3'b010, 5'h0F, 5'h09);
		disp(9'h000, 10'h001, 3'b110, 5'h0E, 5'h02);
		disp(9'h000, 10'h002, 3'b010, `DSD_CH_U, 5'h03);
		disp(9'h000, 10'h100, 3'b110, `DSD_CH_U, 5'h0A);
		disp(9'h000, 10'h000, 3'b000, `DSD_CH_U, 5'h01);
		disp(9'h000, 10'h000, 3'b011, `DSD_CH_P, `DSD_CH_P);
		disp(9'h000, 10'h000, 3'b110, 5'h0E, 5'h0E);
		disp(9'h000, 10'h000, 3'b010, 5'h00, 5'h00);
		for (int i = 0; i < 4; i++) begin
			n = rnd() % 9;
			disp(9'h001 << n, 10'h000, 3'b010, 5'h0F, 5'(n + 1));
		end
		// Mid-run reset, then two warnings shown in turn
		i_sys_rst <= 1'b1;
		repeat (2) @(posedge i_clk);
		`CHK("rst char", `DSD_CH_BLANK, ch)
		`CHK("rst node", 9'h000, {nv, node})
		i_sys_rst <= 1'b0;
		{fault, warn} <= {9'h000, 10'h140};
		repeat (80) @(posedge i_clk);
		m = 32'h0000_0000;
		for (int i = 0; i < 8; i++) begin
			repeat (20) @(posedge i_clk);
			m[ch] = 1'b1;
		end
		`CHK("cycle", 32'h0001_0500, m)
		apb(1'b0, `DSD_REG_STATUS, 32'h0);
		`CHK("status", 12'h540, {rdata[29:28], rdata[21:12]})
		tally_and_finish();
	end
endmodule

// File: dv/dsd_status_display_monitor.sv
// Checker for lamps, node address and bus timing
`timescale 1ns/1ps
module dsd_status_display_monitor (
	input wire i_clk,
	input wire i_sys_rst,
	input wire i_psel,
	input wire i_penable,
	input wire [11:0] i_paddr,
	input wire o_pready,
	input wire o_pslverr,
	input wire [3:0] i_node_sw_upper,
	input wire [3:0] i_node_sw_lower,
	input wire i_dc_bus_high,
	input wire i_mains_applied,
	input wire i_braking_active,
	input wire o_bus_lamp,
	input wire o_mains_lamp,
	input wire o_braking_energy_lamp,
	input wire [7:0] o_node_addr,
	input wire o_node_valid
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);
	chk_bus_lamp: assert property (
		$stable(i_dc_bus_high)[*8] |-> o_bus_lamp == i_dc_bus_high)
		else $error("bus lamp wrong");
	chk_mains_lamp: assert property (
		$stable(i_mains_applied)[*8] |-> o_mains_lamp == i_mains_applied)
		else $error("mains lamp wrong");
	chk_braking_lamp: assert property (
		$stable(i_braking_active)[*8]
		|-> o_braking_energy_lamp == i_braking_active)
		else $error("braking lamp wrong");
	chk_node_addr: assert property (
		$stable({i_node_sw_upper, i_node_sw_lower})[*8]
		|-> o_node_addr == {i_node_sw_upper, i_node_sw_lower})
		else $error("node address wrong");
	chk_node_zero: assert property (
		$stable({i_node_sw_upper, i_node_sw_lower})[*8]
		|-> o_node_valid == |{i_node_sw_upper, i_node_sw_lower})
		else $error("node valid wrong");
	chk_ready_answer: assert property (
		i_psel && i_penable && !o_pready |=> o_pready)
		else $error("no bus answer");
	chk_ready_pulse: assert property (
		o_pready |=> !o_pready)
		else $error("ready too long");
	chk_unmapped_err: assert property (
		o_pready |-> o_pslverr ==
		!(i_paddr inside {12'h000, 12'h004, 12'h008, 12'h00C}))
		else $error("slave error wrong");
endmodule

bind dsd_status_display dsd_status_display_monitor u_mon (
	.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_psel(i_psel),
	.i_penable(i_penable), .i_paddr(i_paddr), .o_pready(o_pready),
	.o_pslverr(o_pslverr), .i_node_sw_upper(i_node_sw_upper),
	.i_node_sw_lower(i_node_sw_lower), .i_dc_bus_high(i_dc_bus_high),
	.i_mains_applied(i_mains_applied), .i_braking_active(i_braking_active),
	.o_bus_lamp(o_bus_lamp), .o_mains_lamp(o_mains_lamp),
	.o_braking_energy_lamp(o_braking_energy_lamp),
	.o_node_addr(o_node_addr), .o_node_valid(o_node_valid));
